// ---- rtl/cfab_filter_timing.v ----
// can acceptance filtering, hit recording and time quantum bit timing
//
// Function
// - mask bit zero: identifier bit accepted whatever filter and received bits hold
// - mask bit one: accept only when filter bit equals received bit
// - complete valid message is compared and loaded into buffer tied to filter
// - legacy: filters 0,1 mask zero to buffer zero; 2-5 mask one to buffer one
// - enhanced and fifo: 16 filters, each with enable; disabled never matches
// - enhanced and fifo: last filter is acceptance filter or mask by config
// - enhanced and fifo: four-bit field per filter picks the target buffer
// - enhanced and fifo: mask select bits per filter choose its mask
// - legacy buffer one hit field holds filter number 000 to 101
// - codes 000 and 001 in buffer one only when rollover enabled
// - rollover: direct buffer zero hits coded 110/111, rolled hits 000/001
// - enhanced and fifo: five-bit hit field holds filter number 0 to 15
// - several matches: lowest numbered filter recorded, ascending order
// - mask and filter writes accepted only in configuration mode
// - stuffed edges at least every six bits keep receive timing in lock
// - bit timing syncs to incoming edges and times transmitted bits
// - bit split into sync, propagation, phase one, phase two segments of quanta
// - nominal bit time programmable from 8 to 25 quanta
// - nominal bit rate at most 1 Mb/s, shortest bit one microsecond
// - one quantum lasts two times prescaler plus one clock periods
// - prescaler taken from bits five down to zero of bit rate config one
// - sync segment lasts exactly one quantum, edge expected within it
// - propagation segment one to eight quanta via three-bit field
`timescale 1ns/100ps
`include "cfab_consts.vh"

module cfab_filter_timing #(
   parameter ID_W   = 29,
   parameter NFILT  = 16,
   parameter ADDR_W = 8
) (
   input  wire              ref_clk,
   input  wire              reset_n,
   input  wire [ADDR_W-1:0] avs_address,
   input  wire              avs_read,
   input  wire              avs_write,
   input  wire [31:0]       avs_writedata,
   output reg  [31:0]       avs_readdata,
   output reg               avs_waitrequest,
   input  wire              message_assembly_buffer_valid,
   input  wire [ID_W-1:0]   message_assembly_buffer_id,
   input  wire              receive_buffer_zero_full,
   input  wire              can_rx,
   output reg               rx_load_ff,
   output reg  [3:0]        rx_load_buffer_ff,
   output reg  [4:0]        filter_hit_field_ff,
   output reg               time_quantum_tick_ff,
   output reg               sync_segment_ff,
   output reg               sample_point_ff,
   output reg               tx_bit_start_ff
);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   reg  [4:0]      ctrl_ff;
   reg  [5:0]      quantum_prescaler_ff;
   reg  [8:0]      brg2_ff;
   reg  [NFILT-1:0] filter_enable_ff;
   reg  [ID_W-1:0] accept_mask_zero_ff;
   reg  [ID_W-1:0] accept_mask_one_ff;
   reg  [63:0]     assoc_ff;
   reg  [31:0]     msel_ff;
   reg  [ID_W-1:0] filt_ff [0:NFILT-1];
   reg             hit_valid_ff;
   reg             miss_ff;
   reg             rx_prev_ff;
   reg  [6:0]      pre_cnt_ff;
   reg  [4:0]      seg_cnt_ff;
   integer         i;

   wire [1:0]      mode       = ctrl_ff[`CFAB_CTRL_MODE_HI:`CFAB_CTRL_MODE_LO];
   wire            cfg_mode   = ctrl_ff[`CFAB_CTRL_CFG];
   wire            rollover   = ctrl_ff[`CFAB_CTRL_ROLL];
   wire            f15_mask   = ctrl_ff[`CFAB_CTRL_F15MASK];
   wire [2:0]      propagation_length_field = brg2_ff[2:0];
   wire [2:0]      phase_segment_one        = brg2_ff[5:3];
   wire [2:0]      phase_segment_two        = brg2_ff[8:6];

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // per-bit truth table folded: masked-off bits accept, others need equality
   function filt_match;
      input [ID_W-1:0] mask;
      input [ID_W-1:0] filt;
      input [ID_W-1:0] id;
      begin
         filt_match = &(~(mask & (filt ^ id)));
      end
   endfunction

   // segment length in quanta from a three-bit field holding length minus one
   function [4:0] seg_len;
      input [2:0] fld;
      begin
         seg_len = {2'b00, fld} + 5'h01;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   wire            req        = avs_read | avs_write;
   wire            wr_go      = avs_write & ~avs_waitrequest;
   wire            filt_sel   = (avs_address >= `CFAB_OFS_FILT_BASE) &&
                                (avs_address <= `CFAB_OFS_FILT_END);
   wire [3:0]      filt_idx   = avs_address[5:2];
   // eight bits: the largest quantum is 128 clocks, one more than seven bits hold
   wire [7:0]      pre_len;
   wire [4:0]      bit_tq     = 5'h01 + seg_len(propagation_length_field) +
                                seg_len(phase_segment_one) + seg_len(phase_segment_two);
   wire            tq_bad     = (bit_tq < `CFAB_TQ_MIN) || (bit_tq > `CFAB_TQ_MAX);
   wire [11:0]     bit_clks   = {4'h0, pre_len} * {7'h00, bit_tq};
   wire            rate_bad   = (bit_clks < `CFAB_BIT_MIN_CLK);

   // one quantum spans 2*(prescaler+1) clocks
   assign pre_len = {1'b0, quantum_prescaler_ff, 1'b0} + 8'h02;

   // read mux; unmapped addresses read zero
   reg  [31:0]     rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      if (filt_sel) begin
         rd_mux[ID_W-1:0] = filt_ff[filt_idx];
      end else begin
         case (avs_address)
            `CFAB_OFS_CTRL:     rd_mux[4:0]      = ctrl_ff;
            `CFAB_OFS_BRG1:     rd_mux[5:0]      = quantum_prescaler_ff;
            `CFAB_OFS_BRG2:     rd_mux[8:0]      = brg2_ff;
            `CFAB_OFS_FEN:      rd_mux[NFILT-1:0] = filter_enable_ff;
            `CFAB_OFS_MASK0:    rd_mux[ID_W-1:0] = accept_mask_zero_ff;
            `CFAB_OFS_MASK1:    rd_mux[ID_W-1:0] = accept_mask_one_ff;
            `CFAB_OFS_ASSOC_LO: rd_mux           = assoc_ff[31:0];
            `CFAB_OFS_ASSOC_HI: rd_mux           = assoc_ff[63:32];
            `CFAB_OFS_MSEL:     rd_mux           = msel_ff;
            `CFAB_OFS_STATUS:   rd_mux[12:0]     = {rate_bad, tq_bad, miss_ff, hit_valid_ff,
                                                    rx_load_buffer_ff, filter_hit_field_ff};
            default:            rd_mux           = 32'h0000_0000;
         endcase
      end
   end

   // one wait cycle per access: the answer lands on the second edge
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else begin
         if (req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= rd_mux;
         end else begin
            avs_waitrequest <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes; filter and mask state is frozen outside configuration
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         ctrl_ff              <= `CFAB_CTRL_RST;
         quantum_prescaler_ff <= 6'h00;
         brg2_ff              <= `CFAB_BRG2_RST;
         filter_enable_ff     <= {NFILT{1'b0}};
         accept_mask_zero_ff  <= {ID_W{1'b0}};
         accept_mask_one_ff   <= {ID_W{1'b0}};
         assoc_ff             <= 64'h0000_0000_0000_0000;
         msel_ff              <= 32'h0000_0000;
         for (i = 0; i < NFILT; i = i + 1) begin
            filt_ff[i] <= {ID_W{1'b0}};
         end
      end else if (wr_go) begin
         case (avs_address)
            `CFAB_OFS_CTRL: ctrl_ff <= avs_writedata[4:0];
            `CFAB_OFS_BRG1: quantum_prescaler_ff <= avs_writedata[5:0];
            `CFAB_OFS_BRG2: brg2_ff <= avs_writedata[8:0];
            default: begin
            end
         endcase
         if (cfg_mode) begin
            case (avs_address)
               `CFAB_OFS_FEN:      filter_enable_ff    <= avs_writedata[NFILT-1:0];
               `CFAB_OFS_MASK0:    accept_mask_zero_ff <= avs_writedata[ID_W-1:0];
               `CFAB_OFS_MASK1:    accept_mask_one_ff  <= avs_writedata[ID_W-1:0];
               `CFAB_OFS_ASSOC_LO: assoc_ff[31:0]      <= avs_writedata;
               `CFAB_OFS_ASSOC_HI: assoc_ff[63:32]     <= avs_writedata;
               `CFAB_OFS_MSEL:     msel_ff             <= avs_writedata;
               default: begin
               end
            endcase
            if (filt_sel) begin
               filt_ff[filt_idx] <= avs_writedata[ID_W-1:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // acceptance search, scanned from the highest filter down so the
   // lowest numbered match is the one left standing
   reg             nxt_hit;
   reg  [3:0]      nxt_num;
   reg  [3:0]      nxt_buf;
   reg  [4:0]      nxt_code;
   reg  [ID_W-1:0] cur_mask;
   reg             f_on;
   integer         k;
   always @* begin
      nxt_hit  = 1'b0;
      nxt_num  = 4'h0;
      nxt_buf  = 4'h0;
      nxt_code = 5'h00;
      cur_mask = {ID_W{1'b0}};
      f_on     = 1'b0;
      for (k = NFILT - 1; k >= 0; k = k - 1) begin
         if (mode == `CFAB_MODE_LEGACY) begin
            // only six filters, fixed mask pairing
            f_on     = (k < 6);
            cur_mask = (k < 2) ? accept_mask_zero_ff : accept_mask_one_ff;
         end else begin
            f_on = filter_enable_ff[k] &&
                   !(f15_mask && (k == NFILT - 1));
            case (msel_ff[2*k +: 2])
               `CFAB_MSEL_M0:  cur_mask = accept_mask_zero_ff;
               `CFAB_MSEL_M1:  cur_mask = accept_mask_one_ff;
               `CFAB_MSEL_F15: cur_mask = f15_mask ? filt_ff[NFILT-1] : {ID_W{1'b0}};
               default:        cur_mask = {ID_W{1'b0}};
            endcase
         end
         if (f_on && filt_match(cur_mask, filt_ff[k], message_assembly_buffer_id)) begin
            nxt_hit = 1'b1;
            nxt_num = k[3:0];
         end
      end
      if (mode == `CFAB_MODE_LEGACY) begin
         if (nxt_num < 4'h2) begin
            if (rollover && receive_buffer_zero_full) begin
               // overflow into buffer one, filter number kept as 000/001
               nxt_buf  = 4'h1;
               nxt_code = {1'b0, nxt_num};
            end else begin
               nxt_buf  = 4'h0;
               nxt_code = rollover ? {2'b00, `CFAB_HIT_DIRECT | {2'b00, nxt_num[0]}}
                                   : {1'b0, nxt_num};
            end
         end else begin
            nxt_buf  = 4'h1;
            nxt_code = {1'b0, nxt_num};
         end
      end else begin
         nxt_buf  = assoc_ff[4*nxt_num +: 4];
         nxt_code = {1'b0, nxt_num};
      end
   end

   // result of a completed message; load strobe is one cycle wide
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         rx_load_ff          <= 1'b0;
         rx_load_buffer_ff   <= 4'h0;
         filter_hit_field_ff <= 5'h00;
         hit_valid_ff        <= 1'b0;
         miss_ff             <= 1'b0;
      end else begin
         rx_load_ff <= 1'b0;
         if (message_assembly_buffer_valid) begin
            rx_load_ff   <= nxt_hit;
            hit_valid_ff <= nxt_hit;
            miss_ff      <= ~nxt_hit;
            if (nxt_hit) begin
               rx_load_buffer_ff   <= nxt_buf;
               filter_hit_field_ff <= nxt_code;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit timing: segment states, one-hot
   localparam [3:0] ST_SYNC = 4'b0001;
   localparam [3:0] ST_PROP = 4'b0010;
   localparam [3:0] ST_PH1  = 4'b0100;
   localparam [3:0] ST_PH2  = 4'b1000;
   reg  [3:0]      st_ff;
   reg  [3:0]      nxt_st;
   reg  [4:0]      nxt_seg_cnt;
   reg             nxt_sample;
   reg             nxt_start;

   // a recessive-to-dominant edge outside the sync segment restarts the bit; the stuffing of the far
   // end guarantees such an edge often enough that drift stays bounded
   wire            rx_fall = rx_prev_ff & ~can_rx;
   wire            tq_end  = (pre_cnt_ff == pre_len - 7'h01);

   always @* begin
      nxt_st      = st_ff;
      nxt_seg_cnt = seg_cnt_ff;
      nxt_sample  = 1'b0;
      nxt_start   = 1'b0;
      if (tq_end) begin
         nxt_seg_cnt = seg_cnt_ff + 5'h01;
         case (st_ff)
            ST_SYNC: begin
               nxt_st      = ST_PROP;
               nxt_seg_cnt = 5'h00;
            end
            ST_PROP: begin
               if (nxt_seg_cnt == seg_len(propagation_length_field)) begin
                  nxt_st      = ST_PH1;
                  nxt_seg_cnt = 5'h00;
               end
            end
            ST_PH1: begin
               if (nxt_seg_cnt == seg_len(phase_segment_one)) begin
                  nxt_st      = ST_PH2;
                  nxt_seg_cnt = 5'h00;
                  nxt_sample  = 1'b1;
               end
            end
            ST_PH2: begin
               if (nxt_seg_cnt == seg_len(phase_segment_two)) begin
                  nxt_st      = ST_SYNC;
                  nxt_seg_cnt = 5'h00;
                  nxt_start   = 1'b1;
               end
            end
            default: begin
               nxt_st      = ST_SYNC;
               nxt_seg_cnt = 5'h00;
            end
         endcase
      end
   end

   // prescaler, segment counters and timing strobes; held in sync while in
   // configuration so a new rate starts from a clean bit
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         rx_prev_ff           <= 1'b1;
         pre_cnt_ff           <= 7'h00;
         seg_cnt_ff           <= 5'h00;
         st_ff                <= ST_SYNC;
         time_quantum_tick_ff <= 1'b0;
         sync_segment_ff      <= 1'b0;
         sample_point_ff      <= 1'b0;
         tx_bit_start_ff      <= 1'b0;
      end else begin
         rx_prev_ff <= can_rx;
         if (cfg_mode || (rx_fall && st_ff != ST_SYNC)) begin
            // restart at the top of the sync quantum
            pre_cnt_ff           <= 7'h00;
            seg_cnt_ff           <= 5'h00;
            st_ff                <= ST_SYNC;
            time_quantum_tick_ff <= 1'b0;
            sample_point_ff      <= 1'b0;
            tx_bit_start_ff      <= ~cfg_mode;
            sync_segment_ff      <= ~cfg_mode;
         end else begin
            pre_cnt_ff           <= tq_end ? 7'h00 : pre_cnt_ff + 7'h01;
            seg_cnt_ff           <= nxt_seg_cnt;
            st_ff                <= nxt_st;
            time_quantum_tick_ff <= tq_end;
            sample_point_ff      <= nxt_sample;
            tx_bit_start_ff      <= nxt_start;
            sync_segment_ff      <= (nxt_st == ST_SYNC);
         end
      end
   end

endmodule

// ---- rtl/cfab_consts.vh ----
// constants for the can acceptance filter and bit timing block
`ifndef CFAB_CONSTS_VH
`define CFAB_CONSTS_VH
// register byte offsets
`define CFAB_OFS_CTRL      8'h00
`define CFAB_OFS_BRG1      8'h04
`define CFAB_OFS_BRG2      8'h08
`define CFAB_OFS_FEN       8'h0c
`define CFAB_OFS_MASK0     8'h10
`define CFAB_OFS_MASK1     8'h14
`define CFAB_OFS_ASSOC_LO  8'h18
`define CFAB_OFS_ASSOC_HI  8'h1c
`define CFAB_OFS_MSEL      8'h20
`define CFAB_OFS_STATUS    8'h24
`define CFAB_OFS_FILT_BASE 8'h40
`define CFAB_OFS_FILT_END  8'h7c
// control fields
`define CFAB_CTRL_CFG      0
`define CFAB_CTRL_MODE_LO  1
`define CFAB_CTRL_MODE_HI  2
`define CFAB_CTRL_ROLL     3
`define CFAB_CTRL_F15MASK  4
`define CFAB_CTRL_RST      5'h01
`define CFAB_MODE_LEGACY   2'h0
`define CFAB_MODE_ENH      2'h1
`define CFAB_MODE_FIFO     2'h2
// mask select codes
`define CFAB_MSEL_M0       2'h0
`define CFAB_MSEL_M1       2'h1
`define CFAB_MSEL_F15      2'h2
// legacy hit codes for direct buffer zero hits
`define CFAB_HIT_DIRECT    3'h6
// bit timing
`define CFAB_TQ_MIN        5'h08
`define CFAB_TQ_MAX        5'h19
`define CFAB_CLK_NS        25
`define CFAB_BIT_MIN_NS    1000
`define CFAB_BIT_MIN_CLK   ((`CFAB_BIT_MIN_NS + `CFAB_CLK_NS - 1) / `CFAB_CLK_NS)
`define CFAB_BRG2_RST      9'h0ff
`endif

// ---- test/cfab_filter_timing_asserts.sv ----
// checker: bus handshake, message load and bit timing properties
`timescale 1ns/100ps
module cfab_filter_timing_asserts (
   input logic        ref_clk,
   input logic        reset_n,
   input logic [7:0]  avs_address,
   input logic        avs_read,
   input logic        avs_write,
   input logic [31:0] avs_readdata,
   input logic        avs_waitrequest,
   input logic        message_assembly_buffer_valid,
   input logic        rx_load_ff,
   input logic [3:0]  rx_load_buffer_ff,
   input logic [4:0]  filter_hit_field_ff,
   input logic        time_quantum_tick_ff,
   input logic        sample_point_ff,
   input logic        tx_bit_start_ff
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // a taken request is answered after exactly one wait cycle
   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest not low one cycle after request");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   unmapped_zero_a: assert property (avs_read && !avs_waitrequest && (avs_address > 8'h7c ||
      (avs_address > 8'h24 && avs_address < 8'h40))
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
   // a load is only ever caused by a complete message one cycle earlier
   load_cause_a: assert property (rx_load_ff |-> $past(message_assembly_buffer_valid))
      else $error("load without message");
   // past reset guard: the first edge after release still compares reset values
   fields_hold_a: assert property (!rx_load_ff && $past(reset_n) |->
      $stable({rx_load_buffer_ff, filter_hit_field_ff})) else $error("hit fields moved");
   hit_width_a: assert property (rx_load_ff |-> filter_hit_field_ff <= 5'h0f)
      else $error("hit code above fifteen");
   tick_gap_a: assert property (time_quantum_tick_ff |=> !time_quantum_tick_ff)
      else $error("quantum shorter than two clocks");
   sample_gap_a: assert property (sample_point_ff |=> !sample_point_ff [*5])
      else $error("sample points too close");
   start_gap_a: assert property (tx_bit_start_ff |=> !tx_bit_start_ff)
      else $error("bit start longer than one cycle");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind cfab_filter_timing cfab_filter_timing_asserts u_chk (.ref_clk(ref_clk),
   .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .message_assembly_buffer_valid(message_assembly_buffer_valid), .rx_load_ff(rx_load_ff),
   .rx_load_buffer_ff(rx_load_buffer_ff), .filter_hit_field_ff(filter_hit_field_ff),
   .time_quantum_tick_ff(time_quantum_tick_ff), .sample_point_ff(sample_point_ff),
   .tx_bit_start_ff(tx_bit_start_ff));

// ---- test/cfab_can_node.sv ----
// behavioural remote can node: sends one stuffed bit pattern, idles recessive
`timescale 1ns/100ps
module cfab_can_node (
   input  logic        ref_clk,
   input  logic        go,
   input  logic [15:0] bit_clks,
   input  logic [31:0] frame,
   output logic        can_rx,
   output logic        busy
);
   logic [15:0] cnt_ff;
   logic [5:0]  idx_ff;
   logic [2:0]  run_ff;
   initial begin
      can_rx = 1'b1;
      busy = 1'b0;
   end
   // one bit per bit_clks cycles; a run of five forces an opposite stuff bit
   always @(posedge ref_clk) begin
      if (go && !busy) begin
         busy <= 1'b1;
         idx_ff <= 6'h20;
         cnt_ff <= 16'h0;
         run_ff <= 3'h0;
      end else if (busy) begin
         if (cnt_ff != 16'h0) cnt_ff <= cnt_ff - 16'h1;
         else if (run_ff == 3'h5) begin
            can_rx <= ~can_rx;
            run_ff <= 3'h1;
            cnt_ff <= bit_clks - 16'h1;
         end else if (idx_ff == 6'h0) begin
            can_rx <= 1'b1; // released bus returns recessive
            busy <= 1'b0;
         end else begin
            can_rx <= frame[idx_ff-6'h1];
            run_ff <= (frame[idx_ff-6'h1] == can_rx) ? run_ff + 3'h1 : 3'h1;
            idx_ff <= idx_ff - 6'h1;
            cnt_ff <= bit_clks - 16'h1;
         end
      end
   end
endmodule

// ---- test/cfab_filter_timing_tb_top.sv ----
// testbench: filters, hit codes, config lock and bit timing of the block
`timescale 1ns/100ps
`include "cfab_consts.vh"
module cfab_filter_timing_tb_top;
   logic ref_clk, reset_n, avs_read, avs_write, avs_waitrequest, mab_vld, rb0_full, can_rx;
   logic ld, tick, sync, samp, start, go, busy;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rdat;
   logic [28:0] mab_id;
   logic [3:0]  ld_buf;
   logic [4:0]  hit;
   int          miscompares = 0;
   int          num_checks = 0;
   cfab_filter_timing DUT (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .message_assembly_buffer_valid(mab_vld), .message_assembly_buffer_id(mab_id),
      .receive_buffer_zero_full(rb0_full), .can_rx(can_rx), .rx_load_ff(ld),
      .rx_load_buffer_ff(ld_buf), .filter_hit_field_ff(hit), .time_quantum_tick_ff(tick),
      .sync_segment_ff(sync), .sample_point_ff(samp), .tx_bit_start_ff(start));
   cfab_can_node u_node (.ref_clk(ref_clk), .go(go), .bit_clks(16'd47),
      .frame(32'h0000_03ff), .can_rx(can_rx), .busy(busy));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // bus master: hold the request until waitrequest is sampled low
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      rdat = avs_readdata;
      avs_read <= 1'b0;
      chk(nm, rdat & m, e);
   endtask
   // one message id; the load answer stands one cycle after the valid pulse
   task automatic msg(input logic [28:0] id, input logic le, input logic [3:0] be,
                      input logic [4:0] he);
      @(posedge ref_clk);
      mab_vld <= 1'b1;
      mab_id <= id;
      @(posedge ref_clk);
      mab_vld <= 1'b0;
      #1;
      chk("load", ld, le);
      if (le) begin
         chk("buffer", ld_buf, be);
         chk("hit", hit, he);
      end
   endtask
   task automatic gap(input string nm, ref logic s, input int e);
      int n;
      n = 0;
      @(posedge ref_clk iff s);
      @(posedge ref_clk iff s);
      do begin
         @(posedge ref_clk);
         n++;
      end while (s !== 1'b1);
      chk(nm, n, e);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_legacy;
      rdchk("ctrl", `CFAB_OFS_CTRL, 32'hffffffff, 32'h1);
      rdchk("brg2", `CFAB_OFS_BRG2, 32'hffffffff, 32'h0ff);
      wr(8'h28, 32'h5);
      rdchk("unmapped", 8'h28, 32'hffffffff, 32'h0);
      wr(`CFAB_OFS_MASK0, 32'h1fffffff);
      wr(`CFAB_OFS_MASK1, 32'h0000000f);
      for (int n = 0; n < 6; n++) wr(8'h40 + 8'(4 * n), 32'(n));
      for (int n = 2; n < 6; n++) msg({25'h1abcde0, 4'(n)}, 1, 1, 5'(n));
      msg(29'h1abcde6, 0, 0, 0);
      msg(29'h10, 0, 0, 0);
      msg(29'h0, 1, 0, 5'h0);
      msg(29'h1, 1, 0, 5'h1);
      wr(`CFAB_OFS_CTRL, 32'h09);
      msg(29'h1, 1, 0, 5'h7);
      rb0_full <= 1'b1;
      msg(29'h1, 1, 1, 5'h1);
      msg(29'h0, 1, 1, 5'h0);
      rb0_full <= 1'b0;
   endtask
   // outside configuration mode filter and mask writes must be dropped
   task automatic t_lock;
      wr(`CFAB_OFS_CTRL, 32'h0);
      wr(`CFAB_OFS_FILT_BASE, 32'h7);
      wr(`CFAB_OFS_MASK0, 32'h0);
      rdchk("filter0", `CFAB_OFS_FILT_BASE, 32'hffffffff, 32'h0);
      rdchk("mask0", `CFAB_OFS_MASK0, 32'hffffffff, 32'h1fffffff);
      msg(29'h0, 1, 0, 5'h0);
   endtask
   task automatic t_enh;
      wr(`CFAB_OFS_CTRL, 32'h13);
      wr(`CFAB_OFS_MASK1, 32'h0);
      wr(8'h4c, 32'h55);
      wr(8'h5c, 32'h0aaa);
      wr(8'h64, 32'h123);
      wr(8'h7c, 32'h0);
      wr(`CFAB_OFS_MSEL, 32'h0008_0040);
      wr(`CFAB_OFS_ASSOC_LO, 32'h9000_5000);
      wr(`CFAB_OFS_ASSOC_HI, 32'hc000_0020);
      wr(`CFAB_OFS_FEN, 32'h0000_8288);
      msg(29'h0aaa, 1, 4'h5, 5'h03);
      wr(`CFAB_OFS_FEN, 32'h0000_8280);
      msg(29'h0aaa, 1, 4'h9, 5'h07);
      msg(29'h0bbb, 1, 4'h2, 5'h09);
      wr(`CFAB_OFS_CTRL, 32'h03);
      wr(8'h7c, 32'h0bbb);
      wr(`CFAB_OFS_FEN, 32'h0000_8080);
      msg(29'h0bbb, 1, 4'hc, 5'h0f);
      wr(`CFAB_OFS_CTRL, 32'h05);
      msg(29'h0aaa, 1, 4'h9, 5'h07);
   endtask
   // bit length flags, quantum, bit period, sync length and resync to bus edges
   task automatic t_timing;
      logic [5:0]  quantum_prescaler[3] = '{6'h0, 6'h3f, 6'h3};
      int          tq[3] = '{2, 128, 8};
      int          n;
      logic        s;
      wr(`CFAB_OFS_BRG1, 32'h0);
      wr(`CFAB_OFS_BRG2, 32'h0);
      rdchk("short bit", `CFAB_OFS_STATUS, 32'h1800, 32'h1800);
      wr(`CFAB_OFS_BRG2, 32'h1ff);
      rdchk("long bit", `CFAB_OFS_STATUS, 32'h1800, 32'h0);
      wr(`CFAB_OFS_CTRL, 32'h0);
      gap("bit period", start, 50);
      @(posedge ref_clk iff !sync);
      @(posedge ref_clk iff sync);
      n = 0;
      while (sync === 1'b1) begin
         @(posedge ref_clk);
         n++;
      end
      chk("sync length", n, 2);
      @(posedge ref_clk iff samp);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (start !== 1'b1);
      chk("sample to start", n, 16);
      go <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         @(posedge ref_clk iff can_rx);
         @(posedge ref_clk iff !can_rx);
         s = sync;
         n = 0;
         repeat (4) begin
            @(posedge ref_clk);
            n = n | int'(start);
         end
         if (!s) chk("resync", n, 1);
      end
      go <= 1'b0;
      // let the node finish its frame so no bus edge restarts a quantum
      @(posedge ref_clk iff !busy);
      for (int k = 0; k < 3; k++) begin
         wr(`CFAB_OFS_BRG1, {25'h0, k == 2, quantum_prescaler[k]});
         gap("quantum", tick, tq[k]);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      reset_n = 1'b0;
      avs_address = 8'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      mab_vld = 1'b0;
      mab_id = 29'h0;
      rb0_full = 1'b0;
      go = 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_legacy();
      t_lock();
      t_enh();
      t_timing();
      summarize();
   end
   // watchdog: the whole run needs well under twenty thousand cycles
   initial begin
      #(25 * 60000);
      miscompares++;
      summarize();
   end
endmodule
